// File: hdl/pwss_consts.vh
// constants for the potentiometer wiper serial slave
// assumes a 40 MHz system clock; included by every design file
`ifndef PWSS_CONSTS_VH
`define PWSS_CONSTS_VH
`define PWSS_CLK_HZ        40000000
`define PWSS_NV_WR_MS      10
`define PWSS_NV_WR_CYC     (`PWSS_CLK_HZ / 1000 * `PWSS_NV_WR_MS)
`define PWSS_TYPE_CODE     4'h5
`define PWSS_ID_TYPE_HI    7
`define PWSS_ID_TYPE_LO    4
`define PWSS_ID_ADDR_HI    3
`define PWSS_ID_ADDR_LO    1
`define PWSS_ID_RW         0
`define PWSS_OP_HI         7
`define PWSS_OP_LO         5
`define PWSS_SEL_HI        3
`define PWSS_SEL_LO        2
`define PWSS_OP_RD_WIPER   3'h4
`define PWSS_OP_WR_WIPER   3'h5
`define PWSS_OP_RD_STORED  3'h5
`define PWSS_OP_WR_STORED  3'h6
`define PWSS_OP_XFR_TO_WIP 3'h6
`define PWSS_OP_XFR_TO_NV  3'h7
`define PWSS_POS_W         10
`define PWSS_TAPS          1024
`define PWSS_POS_RESET     10'h000
`define PWSS_BIT_LAST      3'h7
`endif

// File: hdl/pwss_nv_store.v
// four-word store of wiper positions, the nonvolatile registers
// read data are registered; one write port, one read port on the same clock
`timescale 1ns/100ps
`include "pwss_consts.vh"
module pwss_nv_store (
  clk_sys,
  wr_en,
  wr_sel,
  wr_data,
  rd_sel,
  rd_data
);
  input  wire                    clk_sys;
  input  wire                    wr_en;
  input  wire [1:0]              wr_sel;
  input  wire [`PWSS_POS_W-1:0]  wr_data;
  input  wire [1:0]              rd_sel;
  output reg  [`PWSS_POS_W-1:0]  rd_data;

  // no reset: contents model nonvolatile cells that survive a reset
  reg [`PWSS_POS_W-1:0] mem_q [0:3];

  always @(posedge clk_sys)
  begin
    if (wr_en)
      mem_q[wr_sel] <= wr_data;
    rd_data <= mem_q[rd_sel];
  end
endmodule // pwss_nv_store

// File: hdl/pwss_tap_decode.v
// one-hot tap switch decode of the wiper position
// output is registered so exactly one switch is on between clock edges
`timescale 1ns/100ps
`include "pwss_consts.vh"
module pwss_tap_decode (
  clk_sys,
  sys_rst,
  position,
  tap_sel
);
  input  wire                    clk_sys;
  input  wire                    sys_rst;
  input  wire [`PWSS_POS_W-1:0]  position;
  output reg  [`PWSS_TAPS-1:0]   tap_sel;

  genvar i;
  wire [`PWSS_TAPS-1:0] hit;
  generate
    for (i = 0; i < `PWSS_TAPS; i = i + 1)
    begin : g_tap
      localparam [`PWSS_POS_W-1:0] TAP_IDX = i;
      assign hit[i] = (position == TAP_IDX);
    end
  endgenerate

  always @(posedge clk_sys)
  begin
    if (sys_rst)
      tap_sel <= {{(`PWSS_TAPS-1){1'b0}}, 1'b1};
    else
      tap_sel <= hit;
  end
endmodule // pwss_tap_decode

// File: hdl/pwss_slave.v
// two-wire slave and instruction decoder of the digital potentiometer
// assumes scl and sda come from another domain; sda is open drain, sda_oe low releases it
`timescale 1ns/100ps
`include "pwss_consts.vh"
module pwss_slave #(
  parameter NV_WR_CYCLES = `PWSS_NV_WR_CYC
) (
  clk_sys,
  sys_rst,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  pin_address_bits,
  write_protect_n,
  wiper_position_reg,
  tap_sel,
  nv_busy
);
  input  wire                   clk_sys;
  input  wire                   sys_rst;
  input  wire                   scl_in;
  input  wire                   sda_in;
  output reg                    sda_out;
  output reg                    sda_oe;
  input  wire [2:0]             pin_address_bits;
  input  wire                   write_protect_n;
  output reg  [`PWSS_POS_W-1:0] wiper_position_reg;
  output wire [`PWSS_TAPS-1:0]  tap_sel;
  output reg                    nv_busy;

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ID   = 7'h02;
  localparam [6:0] ST_INS  = 7'h04;
  localparam [6:0] ST_RX   = 7'h08;
  localparam [6:0] ST_TX   = 7'h10;
  localparam [6:0] ST_ACK  = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;

  // two-stage synchronisers; first stages read only by second stages
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  // input delay for filtering: the start/stop compares use delayed scl
  reg [6:0]             state_q;
  reg [2:0]             bit_q;
  reg [7:0]             shf_q;
  reg [1:0]             byte_q;
  reg                   rd_q;
  reg [2:0]             op_q;
  reg [1:0]             sel_q;
  reg                   op_ok_q;
  reg                   ack_drv_q;
  reg [`PWSS_POS_W-1:0] tx_val_q;
  reg [1:0]             hi_q;
  reg                   nv_pend_q;
  reg [1:0]             nv_sel_q;
  reg [`PWSS_POS_W-1:0] nv_data_q;
  reg [23:0]            nv_cnt_q;
  reg                   boot_q;
  reg                   boot_wait_q;
  reg                   nv_wr_q;
  reg                   mem_wr;
  reg  [1:0]            rd_sel;
  wire [`PWSS_POS_W-1:0] nv_rd;

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire [7:0] rx_byte = {shf_q[6:0], sda_s_q};

  // a four-byte command kind, used for the instruction and data steps
  function is_long;
    input       rd;
    input [2:0] op;
    input [1:0] sel;
    begin
      is_long = (rd & op == `PWSS_OP_RD_WIPER & sel == 2'b00) |
                (~rd & op == `PWSS_OP_WR_WIPER & sel == 2'b00) |
                (rd & op == `PWSS_OP_RD_STORED) |
                (~rd & op == `PWSS_OP_WR_STORED);
    end
  endfunction

  function is_xfr;
    input       rd;
    input [2:0] op;
    begin
      is_xfr = (rd & op == `PWSS_OP_XFR_TO_WIP) | (~rd & op == `PWSS_OP_XFR_TO_NV);
    end
  endfunction

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  always @*
  begin
    rd_sel = sel_q;
    if (boot_q | boot_wait_q)
      rd_sel = 2'b00;
  end

  always @*
  begin
    mem_wr = nv_wr_q & write_protect_n;
  end

  pwss_nv_store u_store (
    .clk_sys (clk_sys),
    .wr_en   (mem_wr),
    .wr_sel  (nv_sel_q),
    .wr_data (nv_data_q),
    .rd_sel  (rd_sel),
    .rd_data (nv_rd)
  );

  pwss_tap_decode u_taps (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .position (wiper_position_reg),
    .tap_sel  (tap_sel)
  );

  // nonvolatile write timer; the store takes the word at the end of the cycle
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      nv_busy  <= 1'b0;
      nv_cnt_q <= 24'h000000;
      nv_wr_q  <= 1'b0;
      boot_q   <= 1'b1;
      boot_wait_q <= 1'b0;
    end
    else
    begin
      nv_wr_q <= 1'b0;
      boot_q  <= 1'b0;
      boot_wait_q <= boot_q;
      if (nv_busy)
      begin
        if (nv_cnt_q == NV_WR_CYCLES[23:0] - 24'h000001)
        begin
          nv_busy <= 1'b0;
          nv_wr_q <= 1'b1;
        end
        else
          nv_cnt_q <= nv_cnt_q + 24'h000001;
      end
      else if (nv_pend_q & stop_c & write_protect_n)
      begin
        nv_busy  <= 1'b1;
        nv_cnt_q <= 24'h000000;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q   <= ST_IDLE;
      bit_q     <= 3'h0;
      shf_q     <= 8'h00;
      byte_q    <= 2'h0;
      rd_q      <= 1'b0;
      op_q      <= 3'h0;
      sel_q     <= 2'h0;
      op_ok_q   <= 1'b0;
      ack_drv_q <= 1'b0;
      tx_val_q  <= `PWSS_POS_RESET;
      hi_q      <= 2'h0;
      nv_pend_q <= 1'b0;
      nv_sel_q  <= 2'h0;
      nv_data_q <= `PWSS_POS_RESET;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      wiper_position_reg <= `PWSS_POS_RESET;
    end
    else
    begin
      if (boot_wait_q)
        wiper_position_reg <= nv_rd;
      if (nv_busy)
      begin
        state_q   <= ST_IDLE;
        sda_oe    <= 1'b0;
        nv_pend_q <= 1'b0;
      end
      else if (start_c)
      begin
        state_q   <= ST_ID;
        bit_q     <= 3'h0;
        sda_oe    <= 1'b0;
        nv_pend_q <= 1'b0;
      end
      else if (stop_c)
      begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_IDLE :
            sda_oe <= 1'b0;
          ST_ID, ST_INS, ST_RX :
            if (scl_rise)
            begin
              shf_q <= rx_byte;
              bit_q <= bit_q + 3'h1;
              if (bit_q == `PWSS_BIT_LAST)
              begin
                ack_drv_q <= 1'b0;
                state_q   <= ST_ACK;
                if (state_q == ST_ID)
                begin
                  rd_q   <= rx_byte[`PWSS_ID_RW];
                  byte_q <= 2'h0;
                  if (rx_byte[`PWSS_ID_TYPE_HI:`PWSS_ID_TYPE_LO] == `PWSS_TYPE_CODE &&
                      rx_byte[`PWSS_ID_ADDR_HI:`PWSS_ID_ADDR_LO] == pin_address_bits)
                    ack_drv_q <= 1'b1;
                  else
                    state_q <= ST_IDLE;
                end
                else if (state_q == ST_INS)
                begin
                  op_q    <= rx_byte[`PWSS_OP_HI:`PWSS_OP_LO];
                  sel_q   <= rx_byte[`PWSS_SEL_HI:`PWSS_SEL_LO];
                  byte_q  <= 2'h1;
                  op_ok_q <= is_long(rd_q, rx_byte[`PWSS_OP_HI:`PWSS_OP_LO],
                                     rx_byte[`PWSS_SEL_HI:`PWSS_SEL_LO]) |
                             is_xfr(rd_q, rx_byte[`PWSS_OP_HI:`PWSS_OP_LO]);
                  ack_drv_q <= 1'b1;
                end
                else
                begin
                  ack_drv_q <= op_ok_q;
                  byte_q    <= byte_q + 2'h1;
                  if (byte_q == 2'h1)
                    hi_q <= rx_byte[1:0];
                  else if (op_ok_q & op_q == `PWSS_OP_WR_WIPER & sel_q == 2'b00)
                    wiper_position_reg <= {hi_q, rx_byte};
                  else if (op_ok_q & op_q == `PWSS_OP_WR_STORED)
                  begin
                    nv_sel_q  <= sel_q;
                    nv_data_q <= {hi_q, rx_byte};
                    nv_pend_q <= 1'b1;
                  end
                end
              end
            end
          ST_ACK :
            if (scl_fall)
            begin
              if (sda_oe)
              begin
                // ninth clock over: release, or hold sda low as the first read bit, and move on
                sda_oe <= 1'b0;
                bit_q  <= 3'h0;
                if (byte_q == 2'h0)
                  state_q <= ST_INS;
                else if (byte_q == 2'h1 & op_ok_q & is_xfr(rd_q, op_q))
                begin
                  state_q <= ST_IDLE;
                  if (rd_q)
                    wiper_position_reg <= nv_rd;
                  else
                  begin
                    nv_sel_q  <= sel_q;
                    nv_data_q <= wiper_position_reg;
                    nv_pend_q <= 1'b1;
                  end
                end
                else if (rd_q & op_ok_q & byte_q != 2'h3)
                begin
                  state_q  <= ST_TX;
                  if (byte_q == 2'h1)
                    tx_val_q <= (op_q == `PWSS_OP_RD_WIPER) ? wiper_position_reg : nv_rd;
                  sda_oe   <= 1'b1;
                  sda_out  <= 1'b0;
                end
                else if (byte_q == 2'h3 | ~op_ok_q)
                  state_q <= ST_IDLE;
                else
                  state_q <= ST_RX;
              end
              else if (ack_drv_q)
              begin
                sda_oe  <= 1'b1;
                sda_out <= 1'b0;
              end
              else
                state_q <= ST_IDLE;
            end
          ST_TX :
            if (scl_fall)
            begin
              bit_q <= bit_q + 3'h1;
              if (bit_q == `PWSS_BIT_LAST)
              begin
                sda_oe  <= 1'b0;
                state_q <= ST_MACK;
              end
            end
            else
            begin
              // drive zero only, open drain; six zero pad bits first, then the value MSB first
              sda_oe <= ~((byte_q == 2'h1) ?
                          ((bit_q[2:1] == 2'b11) ? tx_val_q[{3'h4, ~bit_q[0]}] : 1'b0) :
                          tx_val_q[3'h7 - bit_q]);
            end
          ST_MACK :
            if (scl_rise)
            begin
              byte_q <= byte_q + 2'h1;
              bit_q  <= 3'h0;
              state_q <= (sda_s_q | byte_q == 2'h2) ? ST_IDLE : ST_MACK;
            end
            else if (scl_fall & state_q == ST_MACK & byte_q == 2'h2)
              state_q <= ST_TX;
          default :
            state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // pwss_slave

// File: tb/pwss_bus_master.sv
// behavioural two-wire bus master for the wiper serial slave
// assumes the bench resolves sda with a pull-up from sda_low and the slave's pull-down
`timescale 1ns/100ps
module pwss_bus_master (
  input logic clk_sys,
  input logic sda_line,
  output logic scl_out,
  output logic sda_low
);
  initial
  begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  // ten clocks per phase keeps scl well above the slave's eight-clock minimum
  task automatic half;
    repeat (10) @(posedge clk_sys);
    #2;
  endtask
  task automatic m_start;
    sda_low = 1'b0;
    scl_out = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl_out = 1'b0;
  endtask
  task automatic m_stop;
    // let scl settle low before sda moves, as for any data bit
    repeat (2) @(posedge clk_sys);
    #2;
    sda_low = 1'b1;
    half;
    scl_out = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask
  // data moves two clocks after scl falls so the synced edges never coincide
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge clk_sys);
    #2;
    sda_low = !b;
    half;
    scl_out = 1'b1;
    half;
    r = sda_line;
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic r9);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(b9, r9);
  endtask
endmodule // pwss_bus_master

// File: tb/pwss_slave_monitor.sv
// port checker of the wiper serial slave
// assumes sda_in is the resolved open-drain line
`timescale 1ns/100ps
`include "pwss_consts.vh"
module pwss_monitor #(
  parameter NV_WR_CYCLES = 400000
) (
  input logic clk_sys,
  input logic sys_rst,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  input logic [2:0] pin_address_bits,
  input logic write_protect_n,
  input logic [`PWSS_POS_W-1:0] wiper_position_reg,
  input logic [`PWSS_TAPS-1:0] tap_sel,
  input logic nv_busy
);
  logic [31:0] busy_cnt_q;
  logic armed_q = 1'b0;
  // stored words start unknown; tap check waits for the first finished store
  always @(posedge clk_sys)
  begin
    if (sys_rst || !nv_busy)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
    if (!sys_rst && $fell(nv_busy))
      armed_q <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_ack_held;
    sda_oe [*8];
  endsequence
  sequence s_line_idle;
    scl_in && sda_in;
  endsequence
  a_tap_one_hot: assert property (armed_q && !$past(sys_rst) |->
    tap_sel == ({{(`PWSS_TAPS-1){1'b0}}, 1'b1} << $past(wiper_position_reg))) else $error("tap select wrong");
  a_open_drain: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  a_ack_held: assert property ($rose(sda_oe) |-> s_ack_held) else $error("sda pull too short");
  a_data_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  a_busy_silent: assert property (nv_busy |-> !sda_oe) else $error("ack while busy");
  a_busy_bounded: assert property (nv_busy |-> busy_cnt_q < NV_WR_CYCLES) else $error("write too long");
  a_wp_no_write: assert property ($rose(nv_busy) |-> write_protect_n) else $error("write while protected");
  a_busy_at_stop: assert property ($rose(nv_busy) |-> s_line_idle) else $error("write not after stop");
  a_wiper_quiet: assert property ($changed(wiper_position_reg) |-> !$past(nv_busy)) else $error("wiper moved busy");
endmodule // pwss_monitor
bind pwss_slave pwss_monitor #(.NV_WR_CYCLES(NV_WR_CYCLES)) i_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .pin_address_bits(pin_address_bits), .write_protect_n(write_protect_n),
  .wiper_position_reg(wiper_position_reg), .tap_sel(tap_sel), .nv_busy(nv_busy));

// File: tb/pwss_slave_tb.sv
// self-checking bench of the wiper serial slave
// assumes the master model owns scl; sda is open drain with a pull-up
`timescale 1ns/100ps
`include "pwss_consts.vh"
module pwss_slave_tb;
  localparam int NVC = 600;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] pins = 3'h5;
  logic wp_n = 1'b1;
  logic scl, m_low, sda_out, sda_oe, nv_busy, r9;
  logic [7:0] rx;
  logic [`PWSS_POS_W-1:0] wiper;
  logic [`PWSS_TAPS-1:0] taps;
  int fail_count = 0;
  int samples_checked = 0;
  wire sda_line = !(sda_oe && !sda_out) && !m_low;
  always #12.5 clk_sys = !clk_sys;
  pwss_bus_master i_mst (.clk_sys(clk_sys), .sda_line(sda_line), .scl_out(scl), .sda_low(m_low));
  pwss_slave #(.NV_WR_CYCLES(NVC)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .pin_address_bits(pins), .write_protect_n(wp_n), .wiper_position_reg(wiper), .tap_sel(taps),
    .nv_busy(nv_busy));
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #2;
  endtask
  task automatic hdr(input logic rd, input logic [7:0] ins);
    i_mst.m_start;
    i_mst.xfer({`PWSS_TYPE_CODE, pins, rd}, 1'b1, rx, r9);
    chk_bit("id ack", 1'b0, r9);
    i_mst.xfer(ins, 1'b1, rx, r9);
    chk_bit("ins ack", 1'b0, r9);
  endtask
  task automatic wr4(input logic [7:0] ins, input logic [9:0] v);
    hdr(1'b0, ins);
    i_mst.xfer({6'h00, v[9:8]}, 1'b1, rx, r9);
    chk_bit("hi ack", 1'b0, r9);
    i_mst.xfer(v[7:0], 1'b1, rx, r9);
    chk_bit("lo ack", 1'b0, r9);
    i_mst.m_stop;
  endtask
  task automatic rd4(input logic [7:0] ins, input logic [9:0] exp);
    logic [1:0] hi;
    hdr(1'b1, ins);
    i_mst.xfer(8'hFF, 1'b0, rx, r9);
    hi = rx[1:0];
    i_mst.xfer(8'hFF, 1'b1, rx, r9);
    i_mst.m_stop;
    chk_val("read value", exp, {hi, rx});
  endtask
  task automatic poll;
    int n;
    n = 0;
    r9 = 1'b1;
    while (r9 !== 1'b0)
    begin
      i_mst.m_start;
      i_mst.xfer({`PWSS_TYPE_CODE, pins, 1'b0}, 1'b1, rx, r9);
      i_mst.m_stop;
      n++;
      if (n > 20)
      begin
        fail_count++;
        tally_and_finish;
      end
    end
    chk_bit("nack while busy", 1'b1, n > 1);
    chk_bit("busy", 1'b0, nv_busy);
  endtask
  task automatic s_wiper;
    logic [9:0] v;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 10'h3FF : 10'h2A5;
      wr4(8'hA0, v);
      chk_val("wiper", v, wiper);
      chk_bit("tap", 1'b1, taps === ({{(`PWSS_TAPS-1){1'b0}}, 1'b1} << v));
      rd4(8'h80, v);
    end
  endtask
  task automatic s_stored;
    for (int k = 0; k < 4; k++)
    begin
      wr4({3'h6, 1'b0, k[1:0], 2'h0}, {k[1:0], 8'h3C});
      poll;
    end
    for (int k = 0; k < 4; k++)
      rd4({3'h5, 1'b0, k[1:0], 2'h0}, {k[1:0], 8'h3C});
    chk_val("wiper kept", 10'h3FF, wiper);
  endtask
  task automatic s_xfer;
    hdr(1'b1, 8'hC8);
    i_mst.m_stop;
    chk_val("wiper", 10'h23C, wiper);
    wr4(8'hA0, 10'h155);
    hdr(1'b0, 8'hEC);
    i_mst.m_stop;
    poll;
    rd4(8'hAC, 10'h155);
  endtask
  task automatic s_wp;
    wp_n = 1'b0;
    wr4(8'hC4, 10'h2F0);
    chk_bit("busy", 1'b0, nv_busy);
    wp_n = 1'b1;
    rd4(8'hA4, 10'h13C);
  endtask
  task automatic s_addr;
    pins = 3'h2;
    wr4(8'hA0, 10'h0F0);
    chk_val("wiper", 10'h0F0, wiper);
    for (int k = 0; k < 2; k++)
    begin
      i_mst.m_start;
      i_mst.xfer(k ? {~`PWSS_TYPE_CODE, pins, 1'b0} : {`PWSS_TYPE_CODE, 3'h5, 1'b0}, 1'b1, rx, r9);
      chk_bit("foreign id ack", 1'b1, r9);
      i_mst.xfer(8'hA0, 1'b1, rx, r9);
      chk_bit("silent ins", 1'b1, r9);
      i_mst.m_stop;
    end
    chk_val("wiper kept", 10'h0F0, wiper);
    pins = 3'h5;
  endtask
  task automatic s_reset;
    do_reset;
    chk_val("wiper reload", 10'h03C, wiper);
  endtask
  initial
  begin
    do_reset;
    s_wiper;
    s_stored;
    s_xfer;
    s_wp;
    s_addr;
    s_reset;
    tally_and_finish;
  end
endmodule // pwss_slave_tb
